// [phyvc_top.sv]
// Vendor control registers and extended-space portal behind the serial management pins.
`timescale 1ns/1ps
`include "phyvc_cfg.svh"
module phyvc_top
  import phyvc_pkg::*;
(
  // System clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Serial management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // Transceiver state
  input wire logic power_down_in,
  input wire logic auto_mdi_in,
  input wire logic speed_1000_in,
  input wire logic speed_100_in,
  input wire logic speed_10_in,
  input wire logic full_duplex_in,
  input wire logic master_in,
  input wire logic link_check_fail_in,
  // Transceiver controls
  output logic auto_xover_en_out,
  output logic mdi_mode_out,
  output logic clk_gate_en_out,
  output logic pll_en_out,
  output logic pad_static_test_enable_out,
  output logic pad_test_level_out,
  output logic ext_wrap_en_out,
  output logic irq_invert_out,
  output logic jabber_en_out,
  output logic heartbeat_test_enable_out,
  output logic transceiver_reset_out
);
  logic fixed_sel_q, swap_off_q, gate_ovr_q, pll_off_q, pad_en_q, pad_lvl_q;
  logic wrap_q, irq_inv_q, jab_q, hb_q, fail_q;
  logic mdi_q, gate_q, pll_q;
  logic [3:0] srst_cnt_q;
  phyvc_func_t func_q;
  logic [4:0] dev_q;
  logic [15:0] ext_addr_q;
  logic [15:0] ext_mem_q [16];
  logic [15:0] snap_xover_q, snap_spd_q, snap_wrap_q, snap_ctrl_q, snap_pctl_q, snap_pdat_q;
  logic snap_ack_q;
  logic sreq_m_q, sreq_s_q, sreq_d_q;
  logic creq_m_q, creq_s_q, creq_d_q;
  logic sreq_w, creq_w, cmd_wr_w;
  logic [4:0] cmd_reg_w;
  logic [15:0] cmd_data_w;
  logic snap_fire_w, cmd_fire_w;
  logic wr_xover_w, wr_spd_w, wr_wrap_w, wr_ctrl_w, wr_pctl_w, wr_pdat_w;
  logic rd_ctrl_w, rd_pdat_w;
  logic ext_hit_w, ext_inc_w, fail_d;
  logic [15:0] xover_word_w, spd_word_w, wrap_word_w, ctrl_word_w, pctl_word_w, pdat_word_w;

  function automatic logic [15:0] phyvc_bit(input logic v, input int pos);
    return {15'h0000, v} << pos;
  endfunction : phyvc_bit

  // Only a small window of one device is backed by storage; the rest reads zero.
  function automatic logic phyvc_ext_hit(input logic [4:0] dev, input logic [15:0] addr);
    return (dev == `PHYVC_EXT_DEV) && (addr < `PHYVC_EXT_WORDS);
  endfunction : phyvc_ext_hit

  phyvc_mdio_link u_link (
    .mdc_in(mdc_in),
    .rst_in(rst_in),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe_out(mdio_oe_out),
    .snap_req_out(sreq_w),
    .snap_ack_in(snap_ack_q),
    .snap_xover_in(snap_xover_q),
    .snap_spd_in(snap_spd_q),
    .snap_wrap_in(snap_wrap_q),
    .snap_ctrl_in(snap_ctrl_q),
    .snap_pctl_in(snap_pctl_q),
    .snap_pdat_in(snap_pdat_q),
    .cmd_req_out(creq_w),
    .cmd_wr_out(cmd_wr_w),
    .cmd_reg_out(cmd_reg_w),
    .cmd_data_out(cmd_data_w)
  );

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      {sreq_m_q, sreq_s_q, sreq_d_q} <= 3'h0;
      {creq_m_q, creq_s_q, creq_d_q} <= 3'h0;
    end else begin
      {sreq_m_q, sreq_s_q, sreq_d_q} <= {sreq_w, sreq_m_q, sreq_s_q};
      {creq_m_q, creq_s_q, creq_d_q} <= {creq_w, creq_m_q, creq_s_q};
    end
  end

  // Command fields stay stable from their toggle until the header of the next frame ends.
  assign snap_fire_w = sreq_s_q ^ sreq_d_q;
  assign cmd_fire_w = creq_s_q ^ creq_d_q;
  assign wr_xover_w = cmd_fire_w && cmd_wr_w && (cmd_reg_w == `PHYVC_REG_XOVER);
  assign wr_spd_w = cmd_fire_w && cmd_wr_w && (cmd_reg_w == `PHYVC_REG_SPD);
  assign wr_wrap_w = cmd_fire_w && cmd_wr_w && (cmd_reg_w == `PHYVC_REG_WRAP);
  assign wr_ctrl_w = cmd_fire_w && cmd_wr_w && (cmd_reg_w == `PHYVC_REG_CTRL);
  assign wr_pctl_w = cmd_fire_w && cmd_wr_w && (cmd_reg_w == `PHYVC_REG_PORTAL_CTL);
  assign wr_pdat_w = cmd_fire_w && cmd_wr_w && (cmd_reg_w == `PHYVC_REG_PORTAL_DAT);
  assign rd_ctrl_w = cmd_fire_w && !cmd_wr_w && (cmd_reg_w == `PHYVC_REG_CTRL);
  assign rd_pdat_w = cmd_fire_w && !cmd_wr_w && (cmd_reg_w == `PHYVC_REG_PORTAL_DAT);
  assign ext_hit_w = phyvc_ext_hit(dev_q, ext_addr_q);
  assign ext_inc_w = (wr_pdat_w && (func_q == func_inc_rw || func_q == func_inc_wr))
    || (rd_pdat_w && func_q == func_inc_rw);

  // Reserved positions are simply never set in the read words.
  assign xover_word_w = phyvc_bit(fixed_sel_q, `PHYVC_XOVER_FIXED_BIT)
    | phyvc_bit(swap_off_q, `PHYVC_XOVER_OFF_BIT);
  assign spd_word_w = phyvc_bit(gate_ovr_q, `PHYVC_SPD_GATE_OVR_BIT)
    | phyvc_bit(pll_off_q, `PHYVC_SPD_PLL_OFF_BIT)
    | phyvc_bit(pad_en_q, `PHYVC_SPD_PAD_EN_BIT)
    | phyvc_bit(pad_lvl_q, `PHYVC_SPD_PAD_LVL_BIT);
  assign wrap_word_w = phyvc_bit(wrap_q, `PHYVC_WRAP_EN_BIT);
  assign ctrl_word_w = phyvc_bit(irq_inv_q, `PHYVC_CTRL_IRQ_INV_BIT)
    | phyvc_bit(jab_q, `PHYVC_CTRL_JAB_BIT)
    | phyvc_bit(hb_q, `PHYVC_CTRL_HB_BIT)
    | phyvc_bit(speed_1000_in, `PHYVC_CTRL_S1000_BIT)
    | phyvc_bit(speed_100_in, `PHYVC_CTRL_S100_BIT)
    | phyvc_bit(speed_10_in, `PHYVC_CTRL_S10_BIT)
    | phyvc_bit(full_duplex_in, `PHYVC_CTRL_DUPLEX_BIT)
    | phyvc_bit(master_in, `PHYVC_CTRL_MASTER_BIT)
    | phyvc_bit(fail_q, `PHYVC_CTRL_LFAIL_BIT);
  assign pctl_word_w = {func_q, 9'h000, dev_q};
  assign pdat_word_w = (func_q == func_addr) ? ext_addr_q :
                       ext_hit_w ? ext_mem_q[ext_addr_q[3:0]] : 16'h0000;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      snap_ack_q <= 1'b0;
      {snap_xover_q, snap_spd_q, snap_wrap_q} <= 48'h0;
      {snap_ctrl_q, snap_pctl_q, snap_pdat_q} <= 48'h0;
    end else if (snap_fire_w) begin
      snap_ack_q <= ~snap_ack_q;
      {snap_xover_q, snap_spd_q, snap_wrap_q} <= {xover_word_w, spd_word_w, wrap_word_w};
      {snap_ctrl_q, snap_pctl_q, snap_pdat_q} <= {ctrl_word_w, pctl_word_w, pdat_word_w};
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      {fixed_sel_q, swap_off_q} <= {`PHYVC_RST_OFF, `PHYVC_RST_OFF};
      {gate_ovr_q, pll_off_q} <= {`PHYVC_RST_OFF, `PHYVC_RST_OFF};
      {pad_en_q, pad_lvl_q, wrap_q} <= {`PHYVC_RST_OFF, `PHYVC_RST_OFF, `PHYVC_RST_OFF};
      {irq_inv_q, jab_q, hb_q} <= {`PHYVC_RST_OFF, `PHYVC_RST_JAB, `PHYVC_RST_HB};
    end else begin
      if (wr_xover_w) begin
        fixed_sel_q <= cmd_data_w[`PHYVC_XOVER_FIXED_BIT];
        swap_off_q <= cmd_data_w[`PHYVC_XOVER_OFF_BIT];
      end
      if (wr_spd_w) begin
        gate_ovr_q <= cmd_data_w[`PHYVC_SPD_GATE_OVR_BIT];
        pll_off_q <= cmd_data_w[`PHYVC_SPD_PLL_OFF_BIT];
        pad_en_q <= cmd_data_w[`PHYVC_SPD_PAD_EN_BIT];
        pad_lvl_q <= cmd_data_w[`PHYVC_SPD_PAD_LVL_BIT];
      end
      if (wr_wrap_w) wrap_q <= cmd_data_w[`PHYVC_WRAP_EN_BIT];
      if (wr_ctrl_w) begin
        irq_inv_q <= cmd_data_w[`PHYVC_CTRL_IRQ_INV_BIT];
        jab_q <= cmd_data_w[`PHYVC_CTRL_JAB_BIT];
        hb_q <= cmd_data_w[`PHYVC_CTRL_HB_BIT];
      end
    end
  end

  // A failure arriving with the read-clear survives; only a flag already shown is cleared.
  assign fail_d = link_check_fail_in
    || (fail_q && !(rd_ctrl_w && snap_ctrl_q[`PHYVC_CTRL_LFAIL_BIT]));

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fail_q <= 1'b0;
      srst_cnt_q <= 4'h0;
    end else begin
      fail_q <= fail_d;
      if (wr_ctrl_w && cmd_data_w[`PHYVC_CTRL_SRST_BIT]) begin
        srst_cnt_q <= `PHYVC_SRST_CYCLES;
      end else if (srst_cnt_q != 4'h0) begin
        srst_cnt_q <= srst_cnt_q - 4'h1;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      func_q <= func_addr;
      dev_q <= 5'h00;
      ext_addr_q <= 16'h0000;
    end else begin
      if (wr_pctl_w) begin
        func_q <= phyvc_func_t'(cmd_data_w[`PHYVC_FUNC_MSB:`PHYVC_FUNC_LSB]);
        dev_q <= cmd_data_w[`PHYVC_DEV_MSB:0];
      end
      if (wr_pdat_w && func_q == func_addr) begin
        ext_addr_q <= cmd_data_w;
      end else if (ext_inc_w) begin
        ext_addr_q <= ext_addr_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (wr_pdat_w && func_q != func_addr && ext_hit_w) begin
      ext_mem_q[ext_addr_q[3:0]] <= cmd_data_w;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mdi_q <= 1'b0;
      gate_q <= 1'b0;
      pll_q <= 1'b1;
    end else begin
      mdi_q <= swap_off_q ? fixed_sel_q : auto_mdi_in;
      gate_q <= power_down_in && !gate_ovr_q;
      pll_q <= !(power_down_in && pll_off_q);
    end
  end

  assign auto_xover_en_out = !swap_off_q;
  assign mdi_mode_out = mdi_q;
  assign clk_gate_en_out = gate_q;
  assign pll_en_out = pll_q;
  assign pad_static_test_enable_out = pad_en_q;
  assign pad_test_level_out = pad_en_q && pad_lvl_q;
  assign ext_wrap_en_out = wrap_q;
  assign irq_invert_out = irq_inv_q;
  assign jabber_en_out = jab_q;
  assign heartbeat_test_enable_out = hb_q;
  assign transceiver_reset_out = (srst_cnt_q != 4'h0);

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_xover_off;
    wr_xover_w && cmd_data_w[`PHYVC_XOVER_OFF_BIT];
  endsequence
  sequence s_fixed_mdi;
    ##1 !auto_xover_en_out ##1 mdi_mode_out == fixed_sel_q;
  endsequence
  sequence s_srst_write;
    wr_ctrl_w && cmd_data_w[`PHYVC_CTRL_SRST_BIT];
  endsequence

  chk_xover_fixed_mode: assert property (s_xover_off |-> s_fixed_mdi)
    else $error("fixed crossover mode not applied");
  chk_xover_auto_on: assert property (auto_xover_en_out |=> mdi_mode_out == $past(auto_mdi_in))
    else $error("auto crossover result not followed");
  chk_clk_gate: assert property (clk_gate_en_out == $past(power_down_in && !gate_ovr_q))
    else $error("clock gating does not follow power-down and bypass");
  chk_pll_off: assert property (power_down_in && pll_off_q |=> !pll_en_out)
    else $error("PLL not stopped in power-down");
  chk_pad_level: assert property (pad_static_test_enable_out |-> pad_test_level_out == pad_lvl_q)
    else $error("pad test level wrong");
  chk_jabber_stop: assert property (wr_ctrl_w && !cmd_data_w[`PHYVC_CTRL_JAB_BIT]
    |=> !jabber_en_out)
    else $error("jabber counter not stopped");
  chk_soft_reset_pulse: assert property (s_srst_write |=> transceiver_reset_out [*8]
    ##1 !transceiver_reset_out)
    else $error("soft reset pulse length wrong");
  chk_soft_reset_keeps: assert property (s_srst_write |=> $stable(wrap_q) && $stable(swap_off_q)
    && $stable(gate_ovr_q))
    else $error("soft reset disturbed register contents");
  chk_fail_set: assert property (link_check_fail_in |=> fail_q ##1 fail_q || $past(rd_ctrl_w))
    else $error("link-check failure not held");
  chk_fail_clear: assert property (rd_ctrl_w && !link_check_fail_in
    && snap_ctrl_q[`PHYVC_CTRL_LFAIL_BIT] |=> !fail_q)
    else $error("link-check failure not cleared on read");
  chk_addr_incr: assert property (ext_inc_w && !(wr_pdat_w && func_q == func_addr)
    |=> ext_addr_q == $past(ext_addr_q) + 16'h0001)
    else $error("portal address not advanced");
  chk_addr_hold: assert property (rd_pdat_w && func_q == func_inc_wr
    |=> $stable(ext_addr_q))
    else $error("portal address advanced on read with write-only increment");
  chk_snap_answer: assert property (snap_fire_w |=> snap_ack_q != $past(snap_ack_q))
    else $error("snapshot request not answered");
endmodule : phyvc_top

// [phyvc_cfg.svh]
// Register map, field positions, reset values and counts of the management block.
`ifndef PHYVC_CFG_SVH
`define PHYVC_CFG_SVH
`define PHYVC_REG_XOVER 5'h1c
`define PHYVC_REG_SPD 5'h1d
`define PHYVC_REG_WRAP 5'h1e
`define PHYVC_REG_CTRL 5'h1f
`define PHYVC_REG_PORTAL_CTL 5'h0d
`define PHYVC_REG_PORTAL_DAT 5'h0e
`define PHYVC_XOVER_FIXED_BIT 7
`define PHYVC_XOVER_OFF_BIT 6
`define PHYVC_SPD_GATE_OVR_BIT 11
`define PHYVC_SPD_PLL_OFF_BIT 10
`define PHYVC_SPD_PAD_EN_BIT 7
`define PHYVC_SPD_PAD_LVL_BIT 6
`define PHYVC_WRAP_EN_BIT 3
`define PHYVC_CTRL_IRQ_INV_BIT 14
`define PHYVC_CTRL_JAB_BIT 9
`define PHYVC_CTRL_HB_BIT 8
`define PHYVC_CTRL_S1000_BIT 6
`define PHYVC_CTRL_S100_BIT 5
`define PHYVC_CTRL_S10_BIT 4
`define PHYVC_CTRL_DUPLEX_BIT 3
`define PHYVC_CTRL_MASTER_BIT 2
`define PHYVC_CTRL_SRST_BIT 1
`define PHYVC_CTRL_LFAIL_BIT 0
`define PHYVC_FUNC_MSB 15
`define PHYVC_FUNC_LSB 14
`define PHYVC_DEV_MSB 4
`define PHYVC_RST_OFF 1'b0
`define PHYVC_RST_JAB 1'b1
`define PHYVC_RST_HB 1'b1
`define PHYVC_PHY_ADDR 5'h01
`define PHYVC_EXT_DEV 5'h02
`define PHYVC_EXT_WORDS 16'h0010
`define PHYVC_FRAME_ST 2'b01
`define PHYVC_OP_WR 2'b01
`define PHYVC_OP_RD 2'b10
`define PHYVC_PREAMBLE_BITS 6'h20
`define PHYVC_SNAP_AT 6'h04
`define PHYVC_HDR_LAST 5'h0d
`define PHYVC_BODY_LAST 5'h11
`define PHYVC_SRST_CYCLES 4'h8
`endif

// [phyvc_pkg.sv]
// Types shared by the management block.
package phyvc_pkg;
  typedef enum logic [1:0] {
    func_addr,
    func_data,
    func_inc_rw,
    func_inc_wr
  } phyvc_func_t;
  typedef enum logic [1:0] {
    fr_pre,
    fr_hdr,
    fr_body
  } phyvc_frame_t;
endpackage : phyvc_pkg

// [phyvc_mdio_link.sv]
// Serial management frame engine on the management clock.
`timescale 1ns/1ps
`include "phyvc_cfg.svh"
module phyvc_mdio_link
  import phyvc_pkg::*;
(
  // Link clock and reset
  input wire logic mdc_in,
  input wire logic rst_in,
  // Management data pin
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // Snapshot handshake
  output logic snap_req_out,
  input wire logic snap_ack_in,
  input wire logic [15:0] snap_xover_in,
  input wire logic [15:0] snap_spd_in,
  input wire logic [15:0] snap_wrap_in,
  input wire logic [15:0] snap_ctrl_in,
  input wire logic [15:0] snap_pctl_in,
  input wire logic [15:0] snap_pdat_in,
  // Completed access
  output logic cmd_req_out,
  output logic cmd_wr_out,
  output logic [4:0] cmd_reg_out,
  output logic [15:0] cmd_data_out
);
  phyvc_frame_t state_q;
  logic [5:0] ones_q;
  logic [12:0] hdr_q;
  logic [4:0] cnt_q;
  logic [15:0] sh_q;
  logic [15:0] cdat_q;
  logic [4:0] creg_q;
  logic rd_q, wr_q, req_q, ack_m_q, ack_s_q, oe_q, out_q, cmd_q, cwr_q;
  logic [13:0] hdr_w;
  logic snap_ok_w;
  logic hdr_ok_w;
  logic [15:0] rword_w;

  assign hdr_w = {hdr_q, mdio_in};
  assign snap_ok_w = (ack_s_q == req_q);
  assign hdr_ok_w = (hdr_w[13:12] == `PHYVC_FRAME_ST) && (hdr_w[9:5] == `PHYVC_PHY_ADDR)
    && snap_ok_w;
  assign rword_w = (hdr_w[4:0] == `PHYVC_REG_XOVER) ? snap_xover_in :
                   (hdr_w[4:0] == `PHYVC_REG_SPD) ? snap_spd_in :
                   (hdr_w[4:0] == `PHYVC_REG_WRAP) ? snap_wrap_in :
                   (hdr_w[4:0] == `PHYVC_REG_CTRL) ? snap_ctrl_in :
                   (hdr_w[4:0] == `PHYVC_REG_PORTAL_CTL) ? snap_pctl_in :
                   (hdr_w[4:0] == `PHYVC_REG_PORTAL_DAT) ? snap_pdat_in : 16'h0000;
  assign mdio_out = out_q;
  assign mdio_oe_out = oe_q;
  assign snap_req_out = req_q;
  assign cmd_req_out = cmd_q;
  assign cmd_wr_out = cwr_q;
  assign cmd_reg_out = creg_q;
  assign cmd_data_out = cdat_q;

  always_ff @(posedge mdc_in or posedge rst_in) begin
    if (rst_in) begin
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
    end else begin
      ack_m_q <= snap_ack_in;
      ack_s_q <= ack_m_q;
    end
  end

  // The register snapshot is fetched during the preamble, so a read can answer in turnaround.
  always_ff @(posedge mdc_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= fr_pre;
      ones_q <= 6'h00;
      hdr_q <= 13'h0000;
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      cdat_q <= 16'h0000;
      creg_q <= 5'h00;
      {rd_q, wr_q, req_q, oe_q, out_q, cmd_q, cwr_q} <= 7'h00;
    end else begin
      unique case (state_q)
        fr_pre: begin
          if (mdio_in) begin
            if (ones_q != `PHYVC_PREAMBLE_BITS) ones_q <= ones_q + 6'h01;
            if (ones_q == `PHYVC_SNAP_AT && snap_ok_w) req_q <= ~req_q;
          end else begin
            ones_q <= 6'h00;
            if (ones_q == `PHYVC_PREAMBLE_BITS) begin
              state_q <= fr_hdr;
              hdr_q <= 13'h0000;
              cnt_q <= 5'h01;
            end
          end
        end
        fr_hdr: begin
          hdr_q <= hdr_w[12:0];
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == `PHYVC_HDR_LAST) begin
            state_q <= fr_body;
            cnt_q <= 5'h00;
            rd_q <= hdr_ok_w && (hdr_w[11:10] == `PHYVC_OP_RD);
            wr_q <= hdr_ok_w && (hdr_w[11:10] == `PHYVC_OP_WR);
            sh_q <= rword_w;
            creg_q <= hdr_w[4:0];
          end
        end
        fr_body: begin
          cnt_q <= cnt_q + 5'h01;
          if (wr_q && cnt_q >= 5'h02) cdat_q <= {cdat_q[14:0], mdio_in};
          if (rd_q) begin
            oe_q <= (cnt_q != `PHYVC_BODY_LAST);
            out_q <= (cnt_q != 5'h00) && sh_q[15];
            if (cnt_q != 5'h00) sh_q <= {sh_q[14:0], 1'b0};
          end
          if (cnt_q == `PHYVC_BODY_LAST) begin
            state_q <= fr_pre;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            oe_q <= 1'b0;
            out_q <= 1'b0;
            if (rd_q || wr_q) begin
              cmd_q <= ~cmd_q;
              cwr_q <= wr_q;
            end
          end
        end
        default: state_q <= fr_pre;
      endcase
    end
  end

  chk_read_drive: assert property (@(posedge mdc_in) disable iff (rst_in)
    (state_q == fr_body && rd_q && cnt_q == 5'h00) |=> mdio_oe_out [*8])
    else $error("read data not driven through turnaround");
endmodule : phyvc_mdio_link

// [phyvc_smi_host.sv]
// Station management controller model that runs serial management frames.
`timescale 1ns/1ps
module phyvc_smi_host (
  // Management clock and data pin
  output logic mdc_out,
  output logic mdio_out,
  output logic mdio_oe_out,
  input wire logic mdio_in
);
  initial begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
    mdio_oe_out = 1'b0;
  end
  // The clock stands low between frames and the pin is left to its pull-up.
  task automatic frame(input logic wr, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, (wr ? 2'b01 : 2'b10), 5'h01, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      mdio_oe_out = wr || (i < 46);
      mdio_out = bits[63 - i];
      mdc_out = 1'b0;
      #80;
      if (!wr && i >= 48) begin
        rd[63 - i] = mdio_in;
      end
      mdc_out = 1'b1;
      #80;
    end
    mdc_out = 1'b0;
    mdio_oe_out = 1'b0;
    #800;
  endtask : frame
endmodule : phyvc_smi_host

// [tb_phyvc_top.sv]
// Self-checking bench for the vendor registers and the extended-space portal.
`timescale 1ns/1ps
`include "phyvc_cfg.svh"
module tb_phyvc_top;
  localparam logic [4:0] xo = `PHYVC_REG_XOVER;
  localparam logic [4:0] spr = `PHYVC_REG_SPD;
  localparam logic [4:0] wrp = `PHYVC_REG_WRAP;
  localparam logic [4:0] ctr = `PHYVC_REG_CTRL;
  localparam logic [4:0] pctl = `PHYVC_REG_PORTAL_CTL;
  localparam logic [4:0] pdat = `PHYVC_REG_PORTAL_DAT;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic mdc, h_out, h_oe, d_out, d_oe;
  logic pdn = 1'b0;
  logic amdi = 1'b0;
  logic [2:0] spd = 3'h0;
  logic fdx = 1'b0;
  logic mst = 1'b0;
  logic lfail = 1'b0;
  wire logic [10:0] ctl;
  wire logic pin;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  int pulse = 0;
  // The pin has a pull-up when nobody drives it.
  assign pin = d_oe ? d_out : (h_oe ? h_out : 1'b1);
  always #50 mclk_in = ~mclk_in;
  phyvc_smi_host host (.mdc_out(mdc), .mdio_out(h_out), .mdio_oe_out(h_oe), .mdio_in(pin));
  phyvc_top uut (
    .mclk_in(mclk_in), .rst_in(rst_in), .mdc_in(mdc), .mdio_in(pin), .mdio_out(d_out),
    .mdio_oe_out(d_oe), .power_down_in(pdn), .auto_mdi_in(amdi), .speed_1000_in(spd[2]),
    .speed_100_in(spd[1]), .speed_10_in(spd[0]), .full_duplex_in(fdx), .master_in(mst),
    .link_check_fail_in(lfail), .auto_xover_en_out(ctl[10]), .mdi_mode_out(ctl[9]),
    .clk_gate_en_out(ctl[8]), .pll_en_out(ctl[7]), .pad_static_test_enable_out(ctl[6]),
    .pad_test_level_out(ctl[5]), .ext_wrap_en_out(ctl[4]), .irq_invert_out(ctl[3]),
    .jabber_en_out(ctl[2]), .heartbeat_test_enable_out(ctl[1]),
    .transceiver_reset_out(ctl[0])
  );
  always @(negedge mclk_in) begin
    if (ctl[0] === 1'b1) begin
      pulse++;
    end
  end
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  task automatic results();
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    host.frame(1'b1, ra, wd, d);
    @(negedge mclk_in);
  endtask : wr
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] d;
    host.frame(1'b0, ra, 16'h0000, d);
    @(negedge mclk_in);
    check("register read", d, exp);
  endtask : rd
  task automatic outs(input logic [10:0] exp);
    repeat (3) @(negedge mclk_in);
    check("control outputs", {5'h00, ctl}, {5'h00, exp});
  endtask : outs
  task automatic t_reset();
    outs(11'h486);
    rd(xo, 16'h0000);
    rd(ctr, 16'h0300);
    rd(5'h10, 16'h0000);
  endtask : t_reset
  task automatic t_xover();
    amdi = 1'b1;
    outs(11'h686);
    wr(xo, 16'h00c0);
    outs(11'h286);
    wr(xo, 16'h0040);
    outs(11'h086);
    wr(xo, 16'hff3f);
    outs(11'h686);
    rd(xo, 16'h0000);
    amdi = 1'b0;
  endtask : t_xover
  task automatic t_power();
    pdn = 1'b1;
    outs(11'h586);
    wr(spr, 16'h0c00);
    outs(11'h406);
    wr(spr, 16'h00c0);
    outs(11'h5e6);
    wr(spr, 16'h0040);
    outs(11'h586);
    wr(spr, 16'hffff);
    outs(11'h466);
    rd(spr, 16'h0cc0);
    pdn = 1'b0;
    outs(11'h4e6);
    wr(spr, 16'h0000);
  endtask : t_power
  task automatic t_ctrl();
    wr(ctr, 16'h4000);
    outs(11'h488);
    for (int k = 0; k < 3; k++) begin
      spd = 3'b100 >> k;
      fdx = k[0];
      mst = ~k[0];
      rd(ctr, 16'h4000 | ({13'h0, spd} << 4) | {12'h0, fdx, mst, 2'b00});
    end
    spd = 3'h0;
    mst = 1'b0;
    fdx = 1'b0;
    pulse = 0;
    wr(ctr, 16'h4302);
    repeat (20) @(negedge mclk_in);
    check("reset pulse", pulse[15:0], {12'h0, `PHYVC_SRST_CYCLES});
    outs(11'h48e);
    rd(ctr, 16'h4300);
    lfail = 1'b1;
    @(negedge mclk_in);
    lfail = 1'b0;
    rd(ctr, 16'h4301);
    rd(ctr, 16'h4300);
    wr(wrp, 16'hffff);
    outs(11'h49e);
    rd(wrp, 16'h0008);
  endtask : t_ctrl
  task automatic sel(input logic [4:0] dev, input logic [15:0] a, input logic [1:0] fn);
    wr(pctl, {2'b00, 9'h000, dev});
    wr(pdat, a);
    wr(pctl, {fn, 9'h000, dev});
  endtask : sel
  task automatic t_portal();
    sel(5'h02, 16'h0003, 2'h1);
    wr(pdat, 16'ha5a5);
    sel(5'h02, 16'h0003, 2'h1);
    rd(pdat, 16'ha5a5);
    sel(5'h02, 16'h0005, 2'h3);
    for (int k = 1; k < 4; k++) begin
      wr(pdat, 16'h1111 * k[15:0]);
    end
    sel(5'h02, 16'h0007, 2'h3);
    rd(pdat, 16'h3333);
    rd(pdat, 16'h3333);
    sel(5'h02, 16'h0005, 2'h2);
    for (int k = 1; k < 4; k++) begin
      rd(pdat, 16'h1111 * k[15:0]);
    end
    wr(pdat, 16'h4444);
    wr(pdat, 16'h5555);
    sel(5'h02, 16'h0008, 2'h1);
    rd(pdat, 16'h4444);
    sel(5'h02, 16'h0009, 2'h1);
    rd(pdat, 16'h5555);
    sel(5'h02, 16'h0005, 2'h0);
    rd(pdat, 16'h0005);
    sel(5'h03, 16'h0003, 2'h1);
    rd(pdat, 16'h0000);
  endtask : t_portal
  initial begin
    repeat (16) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_in = 1'b0;
    @(negedge mclk_in);
    t_reset();
    t_xover();
    t_power();
    t_ctrl();
    t_portal();
    results();
  end
endmodule : tb_phyvc_top
